// >>> include/socal_regs.vh
`ifndef SOCAL_REGS_VH
`define SOCAL_REGS_VH

// Byte addresses of the calibration block (low byte of each pair)
`define SOCAL_X_ACCEL_OFFSET   6'h10
`define SOCAL_Y_ACCEL_OFFSET   6'h12
`define SOCAL_X_ACCEL_GAIN     6'h14
`define SOCAL_Y_ACCEL_GAIN     6'h16
`define SOCAL_X_TILT_OFFSET    6'h18
`define SOCAL_Y_TILT_OFFSET    6'h1A
`define SOCAL_X_TILT_GAIN      6'h1C
`define SOCAL_Y_TILT_GAIN      6'h1E
`define SOCAL_BASE_HI          2'b01

// Register index inside the block (byte address bits 3:1)
`define SOCAL_IDX_XAO          3'd0
`define SOCAL_IDX_YAO          3'd1
`define SOCAL_IDX_XAG          3'd2
`define SOCAL_IDX_YAG          3'd3
`define SOCAL_IDX_XTO          3'd4
`define SOCAL_IDX_YTO          3'd5
`define SOCAL_IDX_XTG          3'd6
`define SOCAL_IDX_YTG          3'd7

// Field widths and reset values
`define SOCAL_ACCEL_OFF_W      4'd12
`define SOCAL_TILT_OFF_W       4'd9
`define SOCAL_GAIN_W           12
`define SOCAL_MASK_12          16'h0FFF
`define SOCAL_MASK_9           16'h01FF
`define SOCAL_OFF_RST          16'h0000
`define SOCAL_GAIN_RST         16'h0800
`define SOCAL_GAIN_SHIFT       11

// Flash hold time after an update starts
`define SOCAL_CLK_PERIOD_NS    5
`define SOCAL_NV_HOLD_NS       50000
`define SOCAL_NV_HOLD_CYC      (`SOCAL_NV_HOLD_NS / `SOCAL_CLK_PERIOD_NS)

`endif

// >>> logic/socal_lane.v
`timescale 1ns/10ps
`default_nettype none
`include "socal_regs.vh"

// One channel: gain x (raw + offset), gain 0x800 is unity, saturated
module socal_lane #(
    parameter RAW_W = 14
) (
    input  wire [RAW_W-1:0] raw_i,
    input  wire [15:0]      offset_i,
    input  wire [15:0]      gain_i,
    input  wire [3:0]       off_w_i,
    output reg  [RAW_W-1:0] result_o
);

    localparam PW = RAW_W + 14;

    reg signed [RAW_W:0]  sum;
    reg signed [15:0]     off_s;
    reg signed [PW-1:0]   prod;
    reg signed [PW-1:0]   scaled;
    reg signed [PW-1:0]   top;
    reg signed [PW-1:0]   bot;

    always @* begin
        off_s = offset_i << (16 - off_w_i);
        off_s = off_s >>> (16 - off_w_i);
        sum = $signed({raw_i[RAW_W-1], raw_i}) + $signed(off_s[RAW_W:0]);
        prod = sum * $signed({1'b0, gain_i[`SOCAL_GAIN_W-1:0]});
        scaled = prod >>> `SOCAL_GAIN_SHIFT;
        top = $signed({{(PW-RAW_W+1){1'b0}}, {(RAW_W-1){1'b1}}});
        bot = -top - 1;
        if (scaled > top) begin
            result_o = top[RAW_W-1:0];
        end else if (scaled < bot) begin
            result_o = bot[RAW_W-1:0];
        end else begin
            result_o = scaled[RAW_W-1:0];
        end
    end

endmodule

`default_nettype wire

// >>> logic/socal_top.v
`timescale 1ns/10ps
`default_nettype none
`include "socal_regs.vh"

module socal_top #(
    parameter RAW_W       = 14,
    parameter NV_HOLD_CYC = `SOCAL_NV_HOLD_CYC
) (
    input  wire               clk_i,
    input  wire               reset_n_i,
    // Decoded register write (one byte)
    input  wire               wr_en_i,
    input  wire [5:0]         wr_addr_i,
    input  wire [7:0]         wr_data_i,
    // Register read (byte pair)
    input  wire               rd_en_i,
    input  wire [5:0]         rd_addr_i,
    output wire [15:0]        rd_data_o,
    output wire               rd_hit_o,
    // Commands
    input  wire               null_cmd_i,
    input  wire               flash_update_i,
    // Nonvolatile store
    input  wire               nv_restore_i,
    input  wire [127:0]       nv_image_i,
    output wire               nv_store_o,
    output wire [127:0]       nv_image_o,
    output wire               nv_busy_o,
    // Raw samples
    input  wire               sample_valid_i,
    input  wire [RAW_W-1:0]   x_accel_raw_i,
    input  wire [RAW_W-1:0]   y_accel_raw_i,
    input  wire [RAW_W-1:0]   x_tilt_raw_i,
    input  wire [RAW_W-1:0]   y_tilt_raw_i,
    // Calibrated results
    output wire               cal_valid_o,
    output wire [RAW_W-1:0]   x_accel_out_o,
    output wire [RAW_W-1:0]   y_accel_out_o,
    output wire [RAW_W-1:0]   x_tilt_out_o,
    output wire [RAW_W-1:0]   y_tilt_out_o
);

    localparam CNT_W = 16;

    reg  [15:0]        cal_ff [0:7];
    reg  [15:0]        nxt_cal [0:7];
    reg  [RAW_W-1:0]   raw_ff [0:3];
    reg  [RAW_W-1:0]   out_ff [0:3];
    wire [RAW_W-1:0]   lane_res [0:3];
    wire [RAW_W-1:0]   raw_in [0:3];
    reg  [15:0]        rd_data_ff;
    reg                rd_hit_ff;
    reg                cal_valid_ff;
    reg                nv_store_ff;
    reg  [127:0]       nv_image_ff;
    reg                nv_busy_ff;
    reg  [CNT_W-1:0]   nv_cnt_ff;
    reg  [CNT_W-1:0]   nxt_nv_cnt;
    reg                nxt_nv_busy;
    reg  [127:0]       cal_flat;
    wire               wr_hit;
    integer            i;
    integer            j;
    integer            k;
    integer            m;

    // Data mask of a register by index
    function [15:0] data_mask;
        input [2:0] idx;
        begin
            if (idx == `SOCAL_IDX_XTO || idx == `SOCAL_IDX_YTO) begin
                data_mask = `SOCAL_MASK_9;
            end else begin
                data_mask = `SOCAL_MASK_12;
            end
        end
    endfunction

    // Reset value of a register by index
    function [15:0] reset_val;
        input [2:0] idx;
        begin
            if (idx[1]) begin
                reset_val = `SOCAL_GAIN_RST;
            end else begin
                reset_val = `SOCAL_OFF_RST;
            end
        end
    endfunction

    // Offset index of a channel: 0,1 accel and 4,5 tilt
    function [2:0] off_idx;
        input [1:0] ch;
        begin
            off_idx = {ch[1], 1'b0, ch[0]};
        end
    endfunction

    // Byte address inside the calibration block
    function in_block;
        input [5:0] addr;
        begin
            in_block = (addr[5:4] == `SOCAL_BASE_HI);
        end
    endfunction

    // Offset field width of a channel: 0,1 accel and 2,3 tilt
    function [3:0] off_width;
        input [1:0] ch;
        begin
            if (ch[1]) begin
                off_width = `SOCAL_TILT_OFF_W;
            end else begin
                off_width = `SOCAL_ACCEL_OFF_W;
            end
        end
    endfunction

    // Negated reading, saturated to the offset field width
    function [15:0] neg_sat;
        input [RAW_W-1:0] raw;
        input [3:0]       w;
        reg signed [RAW_W:0] neg;
        reg signed [RAW_W:0] lim;
        begin
            neg = -$signed({raw[RAW_W-1], raw});
            lim = $signed({{RAW_W{1'b0}}, 1'b1}) <<< (w - 1);
            if (neg > lim - 1) begin
                neg = lim - 1;
            end else if (neg < -lim) begin
                neg = -lim;
            end
            neg_sat = {{(15-RAW_W){neg[RAW_W]}}, neg} & ((16'h0001 << w) - 16'h0001);
        end
    endfunction

    assign raw_in[0] = x_accel_raw_i;
    assign raw_in[1] = y_accel_raw_i;
    assign raw_in[2] = x_tilt_raw_i;
    assign raw_in[3] = y_tilt_raw_i;

    assign wr_hit = wr_en_i && in_block(wr_addr_i);

    // Register file update: restore, else host byte writes, then null
    always @* begin
        for (i = 0; i < 8; i = i + 1) begin
            nxt_cal[i] = cal_ff[i];
        end
        if (nv_restore_i) begin
            for (i = 0; i < 8; i = i + 1) begin
                nxt_cal[i] = nv_image_i[i*16 +: 16] & data_mask(i[2:0]);
            end
        end else begin
            if (wr_hit) begin
                if (wr_addr_i[0]) begin
                    nxt_cal[wr_addr_i[3:1]][15:8] = wr_data_i;
                end else begin
                    nxt_cal[wr_addr_i[3:1]][7:0] = wr_data_i;
                end
                nxt_cal[wr_addr_i[3:1]] = nxt_cal[wr_addr_i[3:1]]
                                          & data_mask(wr_addr_i[3:1]);
            end
            // Null last, so it wins over an offset write in the same cycle
            if (null_cmd_i) begin
                for (i = 0; i < 4; i = i + 1) begin
                    nxt_cal[off_idx(i[1:0])] = neg_sat(raw_ff[i],
                        off_width(i[1:0]));
                end
            end
        end
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (j = 0; j < 8; j = j + 1) begin
                cal_ff[j] <= reset_val(j[2:0]);
            end
        end else begin
            for (j = 0; j < 8; j = j + 1) begin
                cal_ff[j] <= nxt_cal[j];
            end
        end
    end

    // Calibration lanes, one per channel
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : lane
            localparam [1:0] CH = {g >= 2, (g % 2) == 1};
            socal_lane #(
                .RAW_W    (RAW_W)
            ) u_lane (
                .raw_i    (raw_in[g]),
                .offset_i (cal_ff[off_idx(CH)]),
                .gain_i   (cal_ff[off_idx(CH) + 3'd2]),
                .off_w_i  (off_width(CH)),
                .result_o (lane_res[g])
            );
        end
    endgenerate

    // Sample capture and output registers
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (k = 0; k < 4; k = k + 1) begin
                raw_ff[k] <= {RAW_W{1'b0}};
                out_ff[k] <= {RAW_W{1'b0}};
            end
            cal_valid_ff <= 1'b0;
        end else begin
            cal_valid_ff <= sample_valid_i;
            if (sample_valid_i) begin
                for (k = 0; k < 4; k = k + 1) begin
                    raw_ff[k] <= raw_in[k];
                    out_ff[k] <= lane_res[k];
                end
            end
        end
    end

    // Register read: one cycle, either address of a pair returns both bytes
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_ff <= 16'h0000;
            rd_hit_ff  <= 1'b0;
        end else if (rd_en_i) begin
            rd_hit_ff <= in_block(rd_addr_i);
            if (in_block(rd_addr_i)) begin
                rd_data_ff <= cal_ff[rd_addr_i[3:1]];
            end else begin
                rd_data_ff <= 16'h0000;
            end
        end
    end

    // Flash update: snapshot, store pulse, busy for the hold time
    always @* begin
        for (m = 0; m < 8; m = m + 1) begin
            cal_flat[m*16 +: 16] = cal_ff[m];
        end
        nxt_nv_cnt  = nv_cnt_ff;
        nxt_nv_busy = nv_busy_ff;
        if (nv_busy_ff) begin
            if (nv_cnt_ff == NV_HOLD_CYC[CNT_W-1:0] - 1'b1) begin
                nxt_nv_busy = 1'b0;
                nxt_nv_cnt  = {CNT_W{1'b0}};
            end else begin
                nxt_nv_cnt = nv_cnt_ff + 1'b1;
            end
        end else if (flash_update_i) begin
            nxt_nv_busy = 1'b1;
            nxt_nv_cnt  = {CNT_W{1'b0}};
        end
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            nv_store_ff <= 1'b0;
            nv_image_ff <= 128'h0;
            nv_busy_ff  <= 1'b0;
            nv_cnt_ff   <= {CNT_W{1'b0}};
        end else begin
            nv_store_ff <= flash_update_i && !nv_busy_ff;
            if (flash_update_i && !nv_busy_ff) begin
                nv_image_ff <= cal_flat;
            end
            nv_busy_ff <= nxt_nv_busy;
            nv_cnt_ff  <= nxt_nv_cnt;
        end
    end

    assign rd_data_o     = rd_data_ff;
    assign rd_hit_o      = rd_hit_ff;
    assign nv_store_o    = nv_store_ff;
    assign nv_image_o    = nv_image_ff;
    assign nv_busy_o     = nv_busy_ff;
    assign cal_valid_o   = cal_valid_ff;
    assign x_accel_out_o = out_ff[0];
    assign y_accel_out_o = out_ff[1];
    assign x_tilt_out_o  = out_ff[2];
    assign y_tilt_out_o  = out_ff[3];

endmodule

`default_nettype wire

// >>> sim/sensor_output_calibration_bench.sv
`timescale 1ns/10ps
`default_nettype none
module sensor_output_calibration_bench;
    logic                  clk_i = 1'b0;
    logic                  reset_n_i = 1'b0;
    logic                  sample_valid_i = 1'b0;
    logic                  nv_restore_i = 1'b0;
    logic [127:0]          nv_image_i = '0;
    logic [3:0][13:0]      raw = '0;
    logic [15:0]           q;
    int                    fails = 0;
    int                    check_count = 0;
    int                    cycles = 0;
    wire logic             wr_en, rd_en, null_c, flash_c, cal_v, nv_st, nv_busy, rd_hit;
    wire logic [5:0]       wr_addr, rd_addr;
    wire logic [7:0]       wr_data;
    wire logic [15:0]      rd_data;
    wire logic [127:0]     nv_img;
    wire logic [3:0][13:0] res;
    // Byte written, then word read back and its expected value
    logic [35:0] rows [14] = '{{6'h00,8'hff,6'h10,16'h0000}, {6'h20,8'hff,6'h13,16'h0000},
        {6'h3f,8'hff,6'h15,16'h0800}, {6'h0f,8'hff,6'h17,16'h0800}, {6'h00,8'hff,6'h19,16'h0000},
        {6'h00,8'hff,6'h1a,16'h0000}, {6'h00,8'hff,6'h1c,16'h0800}, {6'h00,8'hff,6'h1f,16'h0800},
        {6'h11,8'hff,6'h10,16'h0f00}, {6'h10,8'h80,6'h11,16'h0f80}, {6'h19,8'hff,6'h18,16'h0100},
        {6'h1c,8'h34,6'h1d,16'h0834}, {6'h17,8'h12,6'h16,16'h0200}, {6'h21,8'h55,6'h3e,16'h0000}};
    logic [13:0] wl [6] = '{{6'h10,8'h0a}, {6'h17,8'h04}, {6'h18,8'hfb}, {6'h19,8'h01},
        {6'h1f,8'h0f}, {6'h1e,8'hff}};
    socal_host host (.clk_i(clk_i), .rd_data_i(rd_data), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
        .wr_data_o(wr_data), .rd_en_o(rd_en), .rd_addr_o(rd_addr), .null_o(null_c),
        .flash_o(flash_c));
    socal_top #(.NV_HOLD_CYC(8)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .wr_en_i(wr_en),
        .wr_addr_i(wr_addr), .wr_data_i(wr_data), .rd_en_i(rd_en), .rd_addr_i(rd_addr),
        .rd_data_o(rd_data), .rd_hit_o(rd_hit), .null_cmd_i(null_c), .flash_update_i(flash_c),
        .nv_restore_i(nv_restore_i), .nv_image_i(nv_image_i), .nv_store_o(nv_st),
        .nv_image_o(nv_img), .nv_busy_o(nv_busy), .sample_valid_i(sample_valid_i),
        .x_accel_raw_i(raw[3]), .y_accel_raw_i(raw[2]), .x_tilt_raw_i(raw[1]),
        .y_tilt_raw_i(raw[0]), .cal_valid_o(cal_v), .x_accel_out_o(res[3]),
        .y_accel_out_o(res[2]), .x_tilt_out_o(res[1]), .y_tilt_out_o(res[0]));
    initial forever #2.5 clk_i = ~clk_i;
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic sample(input logic [55:0] r);
        @(posedge clk_i);
        sample_valid_i <= 1'b1;
        raw <= r;
        @(posedge clk_i);
        sample_valid_i <= 1'b0;
        raw <= ~r;
        #1;
        check(cal_v, 1'b1);
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        foreach (rows[i]) begin
            host.wr_byte(rows[i][35:30], rows[i][29:22]);
            host.rd_word(rows[i][21:16], q);
            check(q, rows[i][15:0]);
            check(rd_hit, rows[i][21:20] == 2'b01);
        end
        $display("Register table test done");
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        @(posedge clk_i);
        reset_n_i <= 1'b1;
        host.rd_word(6'h17, q);
        check(q, 16'h0800);
        host.rd_word(6'h10, q);
        check(q, 16'h0000);
        $display("Mid-run reset test done");
        foreach (wl[i]) host.wr_byte(wl[i][13:8], wl[i][7:0]);
        sample({14'h0064, 14'h00c8, 14'h0032, 14'h3c18});
        check(res, {14'h006e, 14'h0064, 14'h002d, 14'h3830});
        $display("Datapath test done");
        sample({14'h0064, 14'h00c8, 14'h0032, 14'h3f38});
        host.cmd(1'b0);
        host.rd_word(6'h10, q);
        check(q, 16'h0f9c);
        host.rd_word(6'h1a, q);
        check(q, 16'h00c8);
        sample({14'h0064, 14'h00c8, 14'h0032, 14'h3f38});
        check(res, 64'h0);
        $display("Null test done");
        host.cmd(1'b1);
        #1;
        check({nv_st, nv_busy, nv_img[15:0]}, {2'b11, 16'h0f9c});
        host.cmd(1'b1);
        #1;
        check({nv_st, nv_busy}, 2'b01);
        repeat (5) @(posedge clk_i);
        #1;
        check(nv_busy, 1'b1);
        @(posedge clk_i);
        #1;
        check(nv_busy, 1'b0);
        @(posedge clk_i);
        nv_restore_i <= 1'b1;
        nv_image_i <= 128'h7777_6666_5555_4444_3333_2222_1111_0000;
        @(posedge clk_i);
        nv_restore_i <= 1'b0;
        nv_image_i <= '0;
        host.rd_word(6'h15, q);
        check(q, 16'h0222);
        host.rd_word(6'h1b, q);
        check(q, 16'h0155);
        $display("Flash and restore test done");
        print_verdict();
    end
endmodule
`default_nettype wire

// >>> sim/socal_host.sv
`timescale 1ns/10ps
`default_nettype none
// Host side of the serial link, already decoded to byte strobes
module socal_host (
    input  wire logic        clk_i,
    input  wire logic [15:0] rd_data_i,
    output var  logic        wr_en_o = 1'b0,
    output var  logic [5:0]  wr_addr_o = 6'h00,
    output var  logic [7:0]  wr_data_o = 8'h00,
    output var  logic        rd_en_o = 1'b0,
    output var  logic [5:0]  rd_addr_o = 6'h00,
    output var  logic        null_o = 1'b0,
    output var  logic        flash_o = 1'b0
);
    task automatic wr_byte(input logic [5:0] a, input logic [7:0] d);
        logic [15:0] word;
        word = {1'b1, 1'b0, a, d};
        @(posedge clk_i);
        wr_en_o <= word[15];
        wr_addr_o <= word[13:8];
        wr_data_o <= word[7:0];
        @(posedge clk_i);
        wr_en_o <= 1'b0;
        wr_data_o <= ~d;
    endtask
    task automatic rd_word(input logic [5:0] a, output logic [15:0] q);
        @(posedge clk_i);
        rd_en_o <= 1'b1;
        rd_addr_o <= a;
        @(posedge clk_i);
        rd_en_o <= 1'b0;
        rd_addr_o <= ~a;
        #1;
        q = rd_data_i;
    endtask
    // Flash update when f is high, null otherwise
    task automatic cmd(input logic f);
        if (!f) wr_byte(6'h38, 8'h08);
        @(posedge clk_i);
        flash_o <= f;
        null_o <= ~f;
        @(posedge clk_i);
        flash_o <= 1'b0;
        null_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> sim/socal_props.sv
`timescale 1ns/10ps
`default_nettype none
module socal_props #(
    parameter int NV_HOLD_CYC = 8
) (
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        rd_en_i,
    input wire logic [5:0]  rd_addr_i,
    input wire logic [15:0] rd_data_o,
    input wire logic        rd_hit_o,
    input wire logic        flash_update_i,
    input wire logic        sample_valid_i,
    input wire logic        cal_valid_o,
    input wire logic        nv_store_o,
    input wire logic        nv_busy_o
);
    logic [15:0] busy_cnt_ff;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Length of the current flash hold
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_cnt_ff <= 16'h0000;
        end else if (nv_busy_o) begin
            busy_cnt_ff <= busy_cnt_ff + 16'h0001;
        end else begin
            busy_cnt_ff <= 16'h0000;
        end
    end
    property p_cal; sample_valid_i |=> cal_valid_o; endproperty
    a_cal: assert property (p_cal) else $error("no result after sample");
    property p_cal_q; !sample_valid_i |=> !cal_valid_o; endproperty
    a_cal_q: assert property (p_cal_q) else $error("stray result");
    property p_hit; rd_en_i && rd_addr_i[5:4] == 2'b01 |=> rd_hit_o && rd_data_o[15:12] == 4'h0; endproperty
    a_hit: assert property (p_hit) else $error("bad mapped read");
    property p_miss; rd_en_i && rd_addr_i[5:4] != 2'b01 |=> !rd_hit_o && rd_data_o == 16'h0000; endproperty
    a_miss: assert property (p_miss) else $error("bad unmapped read");
    property p_tilt; rd_en_i && rd_addr_i[5:2] == 4'h6 |=> rd_data_o[15:9] == 7'h00; endproperty
    a_tilt: assert property (p_tilt) else $error("tilt offset unused bits set");
    property p_hold; !rd_en_i |=> $stable(rd_data_o) && $stable(rd_hit_o); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_store; flash_update_i && !nv_busy_o |=> nv_store_o && nv_busy_o; endproperty
    a_store: assert property (p_store) else $error("flash update not started");
    property p_once; nv_store_o |-> $past(flash_update_i) && !$past(nv_busy_o); endproperty
    a_once: assert property (p_once) else $error("store without accepted update");
    property p_busy; $fell(nv_busy_o) |-> busy_cnt_ff == NV_HOLD_CYC; endproperty
    a_busy: assert property (p_busy) else $error("flash hold wrong length");
endmodule
bind socal_top socal_props #(.NV_HOLD_CYC(NV_HOLD_CYC)) u_props (.clk_i, .reset_n_i, .rd_en_i,
    .rd_addr_i, .rd_data_o, .rd_hit_o, .flash_update_i, .sample_valid_i, .cal_valid_o,
    .nv_store_o, .nv_busy_o);
`default_nettype wire
